// *** shared/rcad_pkg.sv ***
package rcad_pkg;

    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int PC_W = 12;
    localparam int FADDR_W = 7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PER_INSTR = 4;
    localparam int INSTR_PERIOD_NS = CLK_PERIOD_NS * OSC_PER_INSTR;

    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int CLASS_HI = 13;
    localparam int CLASS_LO = 12;
    localparam int OP_HI = 11;
    localparam int OP_LO = 8;
    localparam int DEST_BIT = 7;
    localparam logic [1:0] CLASS_FILE = 2'h0;
    localparam logic [1:0] CLASS_WREG = 2'h1;
    localparam logic [1:0] CLASS_LIT = 2'h2;
    localparam logic [1:0] CLASS_GOTO = 2'h3;
    localparam logic [INSTR_W-1:0] INSTR_NOP = 14'h0000;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_STORE_W = 4'h1;
    localparam logic [3:0] OP_CLEAR = 4'h2;
    localparam logic [3:0] OP_SUB = 4'h3;
    localparam logic [3:0] OP_DEC = 4'h4;
    localparam logic [3:0] OP_OR = 4'h5;
    localparam logic [3:0] OP_AND = 4'h6;
    localparam logic [3:0] OP_XOR = 4'h7;
    localparam logic [3:0] OP_ADD = 4'h8;
    localparam logic [3:0] OP_MOVE = 4'h9;
    localparam logic [3:0] OP_COMP = 4'ha;
    localparam logic [3:0] OP_INC = 4'hb;
    localparam logic [3:0] OP_ROT_R = 4'hc;
    localparam logic [3:0] OP_ROT_L = 4'hd;
    localparam logic [3:0] OP_SWAP = 4'he;

    // ------------------------------------------------------------
    // special function register map and status layout
    // ------------------------------------------------------------
    localparam logic [FADDR_W-1:0] ADDR_INDIRECT = 7'h00;
    localparam logic [FADDR_W-1:0] ADDR_PC_LOW = 7'h02;
    localparam logic [FADDR_W-1:0] ADDR_STATUS = 7'h03;
    localparam logic [FADDR_W-1:0] ADDR_POINTER = 7'h04;
    localparam int STAT_CARRY = 0;
    localparam int STAT_DIGIT = 1;
    localparam int STAT_ZERO = 2;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [DATA_W-1:0] W_RST = 8'h00;
    localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 12'h000;

    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_EXEC,
        PH_FETCH
    } rcad_phase_t;

endpackage

// *** verilog/rcad_ram.sv ***
`timescale 1ns/100ps
module rcad_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port, data one clock after the address
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_q
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end

endmodule

// *** verilog/rcad_core.sv ***
// Overview of operation
// - each instruction cycle fetches one whole 14-bit word over the program bus.
// - the fetch of the next word overlaps execution; branches cost a second cycle.
// - the arithmetic unit is 8 bits wide and adds, subtracts, shifts and does logic.
// - arithmetic results wrap as two's complement values.
// - two-operand operations take one operand from the working accumulator.
// - the other operand is a file register or the instruction's immediate byte.
// - single-operand operations act on the accumulator or on one file register.
// - the accumulator is an 8-bit register that no data address reaches.
// - carry, digit carry and zero in status are updated as the operation dictates.
// - on subtraction carry and digit carry read as inverted borrows.
// - special registers, the program counter among them, sit in data space.
// - every operation works on every file register, direct or indirect.
// - in rc mode a clock output runs at a quarter of the core clock.
// - holding master clear low keeps the core in reset.
`timescale 1ns/100ps
module rcad_core
    import rcad_pkg::*;
#(
    parameter int RAM_AW = FADDR_W
) (
    // clock and resets
    input wire logic mclk,
    input wire logic rst,
    input wire logic master_clear_n,
    // oscillator mode strap
    input wire logic rc_mode,
    // program bus
    output logic [PC_W-1:0] prog_addr,
    input wire logic [INSTR_W-1:0] prog_data,
    // observation
    output logic instruction_rate_output,
    output logic [DATA_W-1:0] acc_value,
    output logic [2:0] status_flags
);

    // ------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------
    // returns {carry, digit carry, result}; a is the accumulator, b the other operand
    function automatic logic [DATA_W+1:0] alu_f(
        input logic [3:0] op,
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b,
        input logic cin
    );
        logic [DATA_W:0] s;
        logic [4:0] h;
        s = {1'b0, b} + {1'b0, a};
        h = {1'b0, b[3:0]} + {1'b0, a[3:0]};
        alu_f = {s[DATA_W], h[4], s[DATA_W-1:0]};
        unique case (op)
            OP_ADD: alu_f = {s[DATA_W], h[4], s[DATA_W-1:0]};
            OP_SUB: begin
                // b - a via inverted a; carry out is the inverted borrow
                s = {1'b0, b} + {1'b0, ~a} + 9'h001;
                h = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
                alu_f = {s[DATA_W], h[4], s[DATA_W-1:0]};
            end
            OP_STORE_W: alu_f = {2'h0, a};
            OP_MOVE: alu_f = {2'h0, b};
            OP_CLEAR: alu_f = {2'h0, 8'h00};
            OP_OR: alu_f = {2'h0, a | b};
            OP_AND: alu_f = {2'h0, a & b};
            OP_XOR: alu_f = {2'h0, a ^ b};
            OP_COMP: alu_f = {2'h0, ~b};
            OP_INC: alu_f = {2'h0, b + 8'h01};
            OP_DEC: alu_f = {2'h0, b - 8'h01};
            OP_ROT_R: alu_f = {b[0], 1'b0, cin, b[DATA_W-1:1]};
            OP_ROT_L: alu_f = {b[DATA_W-1], 1'b0, b[DATA_W-2:0], cin};
            OP_SWAP: alu_f = {2'h0, b[3:0], b[7:4]};
            default: alu_f = {2'h0, a};
        endcase
    endfunction

    // which flags an operation touches: {zero, digit, carry}
    function automatic logic [2:0] affects_f(input logic [3:0] op);
        unique case (op)
            OP_ADD, OP_SUB: affects_f = 3'h7;
            OP_ROT_R, OP_ROT_L: affects_f = 3'h1;
            OP_CLEAR, OP_OR, OP_AND, OP_XOR, OP_MOVE, OP_COMP, OP_INC,
            OP_DEC: affects_f = 3'h4;
            default: affects_f = 3'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rcad_phase_t phase_q, phase_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [INSTR_W-1:0] ir_q, ir_d;
    logic flush_q, flush_d;
    logic [DATA_W-1:0] w_q, w_d;
    logic [DATA_W-1:0] ptr_q, ptr_d;
    logic [2:0] status_q, status_d;
    logic rate_q, rate_d;

    logic core_rst;
    assign core_rst = rst | ~master_clear_n;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [1:0] iclass;
    logic [3:0] op;
    logic dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [FADDR_W-1:0] eff_addr;
    logic [DATA_W-1:0] literal;
    logic is_file, is_wreg, is_lit, is_goto;

    assign iclass = ir_q[CLASS_HI:CLASS_LO];
    assign op = ir_q[OP_HI:OP_LO];
    assign dest_file = ir_q[DEST_BIT];
    assign faddr = ir_q[FADDR_W-1:0];
    assign literal = ir_q[DATA_W-1:0];
    assign is_file = (iclass == CLASS_FILE);
    assign is_wreg = (iclass == CLASS_WREG);
    assign is_lit = (iclass == CLASS_LIT);
    assign is_goto = (iclass == CLASS_GOTO);
    // indirect slot resolves through the pointer register for any operation
    assign eff_addr = (faddr == ADDR_INDIRECT) ? ptr_q[FADDR_W-1:0] : faddr;

    // ------------------------------------------------------------
    // file register read: special registers or ram
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ram_rdata;
    logic [DATA_W-1:0] file_value;
    logic [DATA_W-1:0] status_byte;

    assign status_byte = {5'h00, status_q};
    always_comb begin
        unique case (eff_addr)
            ADDR_INDIRECT: file_value = 8'h00;
            ADDR_PC_LOW: file_value = pc_q[DATA_W-1:0];
            ADDR_STATUS: file_value = status_byte;
            ADDR_POINTER: file_value = ptr_q;
            default: file_value = ram_rdata;
        endcase
    end

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    logic [DATA_W-1:0] operand_b;
    logic [DATA_W+1:0] alu_out;
    logic [DATA_W-1:0] result;
    logic [2:0] aff;
    logic [2:0] new_flags;
    logic exec_now;
    logic to_file;
    logic to_w;
    logic file_we;

    // accumulator is always operand a; b is file, accumulator or literal
    assign operand_b = is_file ? file_value : (is_lit ? literal : w_q);
    assign alu_out = alu_f(op, w_q, operand_b, status_q[STAT_CARRY]);
    assign result = alu_out[DATA_W-1:0];
    assign aff = is_goto ? 3'h0 : affects_f(op);
    assign new_flags = {(result == 8'h00), alu_out[DATA_W], alu_out[DATA_W+1]};
    assign exec_now = (phase_q == PH_EXEC) && !is_goto;
    assign to_file = is_file && (dest_file || op == OP_STORE_W) && op != OP_NOP;
    assign to_w = (is_wreg || is_lit || (is_file && !dest_file)) && op != OP_STORE_W
                  && op != OP_NOP;
    assign file_we = exec_now && to_file;

    logic ram_we;
    assign ram_we = file_we && eff_addr != ADDR_INDIRECT && eff_addr != ADDR_PC_LOW
                    && eff_addr != ADDR_STATUS && eff_addr != ADDR_POINTER;

    rcad_ram #(
        .AW(RAM_AW),
        .DW(DATA_W)
    ) u_ram (
        .clk(mclk),
        .we(ram_we),
        .waddr(eff_addr),
        .wdata(result),
        .raddr(eff_addr),
        .rdata_q(ram_rdata)
    );

    logic pcl_write;
    logic take_branch;
    logic [PC_W-1:0] branch_target;

    assign pcl_write = file_we && eff_addr == ADDR_PC_LOW;
    assign take_branch = (phase_q == PH_EXEC) && (is_goto || pcl_write);
    assign branch_target = is_goto ? ir_q[PC_W-1:0] : {pc_q[PC_W-1:DATA_W], result};

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            PH_DECODE: phase_d = PH_READ;
            PH_READ: phase_d = PH_EXEC;
            PH_EXEC: phase_d = PH_FETCH;
            PH_FETCH: phase_d = PH_DECODE;
        endcase
    end

    // accumulator has no address, only instructions reach it
    assign w_d = (exec_now && to_w) ? result : w_q;
    assign ptr_d = (file_we && eff_addr == ADDR_POINTER) ? result : ptr_q;

    always_comb begin
        status_d = status_q;
        if (file_we && eff_addr == ADDR_STATUS) begin
            status_d = result[2:0];
        end
        // flag updates from the operation win over a direct status write
        if (exec_now) begin
            status_d = (status_d & ~aff) | (new_flags & aff);
        end
    end

    // a branch drops the word fetched in its own cycle and holds the pc there,
    // so the target is fetched again one cycle later: one extra cycle per branch
    assign flush_d = take_branch ? 1'b1 : ((phase_q == PH_FETCH) ? 1'b0 : flush_q);
    assign pc_d = take_branch ? branch_target
                  : ((phase_q == PH_FETCH && !flush_q) ? pc_q + 12'h001 : pc_q);
    assign ir_d = (phase_q == PH_FETCH) ? (flush_q ? INSTR_NOP : prog_data) : ir_q;
    assign rate_d = rc_mode && (phase_d == PH_EXEC || phase_d == PH_FETCH);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (core_rst) begin
            phase_q <= PH_DECODE;
            pc_q <= PC_RST;
            ir_q <= INSTR_NOP;
            flush_q <= 1'b0;
            rate_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            pc_q <= pc_d;
            ir_q <= ir_d;
            flush_q <= flush_d;
            rate_q <= rate_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (core_rst) begin
            w_q <= W_RST;
            ptr_q <= POINTER_RST;
            status_q <= STATUS_RST;
        end else begin
            w_q <= w_d;
            ptr_q <= ptr_d;
            status_q <= status_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prog_addr = pc_q;
    assign instruction_rate_output = rate_q;
    assign acc_value = w_q;
    assign status_flags = status_q;

endmodule

// *** verif/rcad_core_chk.sv ***
`timescale 1ns/100ps
module rcad_core_chk
    import rcad_pkg::*;
(
    // clock and resets
    input wire logic mclk,
    input wire logic rst,
    input wire logic master_clear_n,
    // strap and program bus
    input wire logic rc_mode,
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [INSTR_W-1:0] prog_data,
    // observation
    input wire logic instruction_rate_output,
    input wire logic [DATA_W-1:0] acc_value,
    input wire logic [2:0] status_flags
);
    // ----
    // phase tracker
    // ----
    wire logic in_rst = rst | ~master_clear_n;
    logic [1:0] ph_q;
    logic run_q;

    // sampled ph_q is the edge count since release modulo one instruction cycle
    always_ff @(posedge mclk) begin
        if (in_rst) begin
            ph_q <= 2'h0;
            run_q <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            run_q <= run_q | (ph_q == 2'h3);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (in_rst);

    // ----
    // properties
    // ----
    // a branch moves the pc at the exec edge and the fetch edge after it holds the pc;
    // limitation: a jump to its own fall-through word looks like a plain step
    AST_PC_STEP: assert property (ph_q == 2'h0 && $past(ph_q) == 2'h3
        && $past(prog_addr) == $past(prog_addr, 2)
        |-> prog_addr == $past(prog_addr) + 12'h001) else $error("pc step");
    AST_BRANCH_HOLD: assert property (ph_q == 2'h0 && $past(ph_q) == 2'h3
        && $past(prog_addr) != $past(prog_addr, 2)
        |-> $stable(prog_addr)) else $error("pc stepped after branch");
    AST_PC_PHASE: assert property ($changed(prog_addr)
        |-> ph_q == 2'h3 || ph_q == 2'h0) else $error("pc moved mid cycle");
    AST_ACC_PHASE: assert property ($changed(acc_value) |-> ph_q == 2'h3)
        else $error("acc moved off exec");
    AST_STAT_PHASE: assert property ($changed(status_flags) |-> ph_q == 2'h3)
        else $error("flags moved off exec");
    AST_FIRST_EXEC: assert property ($changed({acc_value, status_flags}) |-> run_q)
        else $error("result before first fetch");
    AST_HOLD_ADDR: assert property (!run_q |-> prog_addr == 12'h000)
        else $error("pc left zero early");
    // master clear is checked on its own, so rst alone disables it
    AST_CLEAR: assert property (@(posedge mclk) disable iff (rst) !master_clear_n
        |=> prog_addr == 12'h000 && acc_value == 8'h00 && status_flags == 3'h0)
        else $error("master clear ignored");
    AST_RATE_OFF: assert property (!$past(rc_mode) |-> !instruction_rate_output)
        else $error("rate output without rc mode");
    AST_RATE_WAVE: assert property (@(posedge mclk) disable iff (in_rst || !rc_mode)
        $rose(instruction_rate_output) && $past(rc_mode, 2) |=> instruction_rate_output
        ##1 (!instruction_rate_output) [*2] ##1 instruction_rate_output)
        else $error("rate output not quarter rate");

    COV_ZERO: cover property (status_flags[STAT_ZERO] && $changed(acc_value));
    COV_BRANCH: cover property ($changed(prog_addr) && ph_q == 2'h3);
    COV_RATE: cover property ($rose(instruction_rate_output));
endmodule

bind rcad_core rcad_core_chk i_rcad_core_chk (.mclk, .rst, .master_clear_n, .rc_mode,
    .prog_addr, .prog_data, .instruction_rate_output, .acc_value, .status_flags);

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
    import rcad_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic master_clear_n = 1'b1;
    logic rc_mode = 1'b1;
    logic [PC_W-1:0] prog_addr;
    logic [INSTR_W-1:0] prog_data = INSTR_NOP;
    logic instruction_rate_output;
    logic [DATA_W-1:0] acc_value;
    logic [2:0] status_flags;
    logic [INSTR_W-1:0] rom [0:31];
    logic [INSTR_W-1:0] prg [$];
    int error_cnt = 0;
    int comparisons = 0;
    int ticks = 0;

    rcad_core i_rcad_core (.mclk, .rst, .master_clear_n, .rc_mode, .prog_addr, .prog_data,
        .instruction_rate_output, .acc_value, .status_flags);

    initial forever #5 mclk = ~mclk;

    // program memory answers one small delay after each edge
    always @(posedge mclk) begin
        #1;
        prog_data = rom[prog_addr[4:0]];
    end

    // a hang costs a mismatch
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    // ----
    // helpers
    // ----
    function automatic logic [13:0] lit(input logic [3:0] o, input logic [7:0] v);
        return {CLASS_LIT, o, v};
    endfunction
    function automatic logic [13:0] fil(input logic [3:0] o, input logic [7:0] v);
        return {CLASS_FILE, o, v};
    endfunction
    function automatic logic [13:0] jmp(input logic [7:0] v);
        return {CLASS_GOTO, 4'h0, v};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // unused words all jump to the first unused word, which loops on itself, so the result holds
    task automatic rst_go();
        for (int i = 0; i < 32; i++) begin
            rom[i] = (i < prg.size()) ? prg[i] : jmp(8'(prg.size()));
        end
        @(posedge mclk);
        #1;
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        #1;
        rst = 1'b0;
    endtask

    task automatic run_prog(input logic [7:0] acc_exp, input logic [2:0] st_exp);
        rst_go();
        repeat ((prg.size() + 4) * 4) @(posedge mclk);
        #1;
        chk(acc_value, acc_exp);
        chk(status_flags, st_exp);
    endtask

    task automatic count_rate(output logic [3:0] hi);
        hi = 4'h0;
        repeat (8) begin
            @(posedge mclk);
            #1;
            hi = hi + {3'h0, instruction_rate_output};
        end
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_fetch();
        logic [3:0] hi;
        prg = '{INSTR_NOP, INSTR_NOP, INSTR_NOP};
        rst_go();
        repeat (4) @(posedge mclk);
        #1;
        chk(prog_addr, 12'h001);
        repeat (4) @(posedge mclk);
        #1;
        chk(prog_addr, 12'h002);
        count_rate(hi);
        chk(hi, 4'h4);
        rc_mode = 1'b0;
        repeat (2) @(posedge mclk);
        count_rate(hi);
        chk(hi, 4'h0);
        rc_mode = 1'b1;
    endtask

    task automatic t_arith();
        prg = '{lit(OP_MOVE, 8'h0f), lit(OP_ADD, 8'h01)};
        run_prog(8'h10, 3'h2);
        prg = '{lit(OP_MOVE, 8'h10), lit(OP_ADD, 8'hf0)};
        run_prog(8'h00, 3'h5);
        prg = '{lit(OP_MOVE, 8'h01), lit(OP_SUB, 8'h00)};
        run_prog(8'hff, 3'h0);
        prg = '{lit(OP_MOVE, 8'h01), lit(OP_SUB, 8'h03)};
        run_prog(8'h02, 3'h3);
        prg = '{lit(OP_MOVE, 8'h3c), lit(OP_AND, 8'h0f), lit(OP_OR, 8'h40), lit(OP_XOR, 8'h4c)};
        run_prog(8'h00, 3'h4);
        prg = '{lit(OP_MOVE, 8'h81), {CLASS_WREG, OP_ROT_R, 8'h00}};
        run_prog(8'h40, 3'h1);
    endtask

    task automatic t_operands();
        prg = '{lit(OP_MOVE, 8'h5a), fil(OP_STORE_W, 8'ha0), {CLASS_WREG, OP_CLEAR, 8'h00},
            fil(OP_ADD, 8'h20)};
        run_prog(8'h5a, 3'h0);
        prg = '{lit(OP_MOVE, 8'h22), fil(OP_STORE_W, 8'h84), lit(OP_MOVE, 8'hf0),
            fil(OP_STORE_W, 8'h80), fil(OP_COMP, 8'ha2), fil(OP_INC, 8'ha2),
            fil(OP_MOVE, 8'h22)};
        run_prog(8'h10, 3'h0);
    endtask

    task automatic t_space();
        prg = '{lit(OP_MOVE, 8'hff), fil(OP_STORE_W, 8'h83)};
        run_prog(8'hff, 3'h7);
        prg = '{lit(OP_MOVE, 8'h05), fil(OP_STORE_W, 8'h82), lit(OP_ADD, 8'h01),
            lit(OP_ADD, 8'h01), lit(OP_ADD, 8'h01), lit(OP_ADD, 8'h40)};
        run_prog(8'h45, 3'h0);
        prg = '{jmp(8'h02), lit(OP_MOVE, 8'h11), lit(OP_MOVE, 8'h22)};
        run_prog(8'h22, 3'h0);
    endtask

    task automatic t_clear();
        prg = '{lit(OP_MOVE, 8'h77), lit(OP_ADD, 8'h99)};
        run_prog(8'h10, 3'h3);
        master_clear_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk({acc_value, 1'b0, status_flags}, 12'h000);
        chk(prog_addr, 12'h000);
        master_clear_n = 1'b1;
        repeat (28) @(posedge mclk);
        #1;
        chk(acc_value, 8'h10);
    endtask

    initial begin
        t_fetch();
        t_arith();
        t_operands();
        t_space();
        t_clear();
        final_report();
    end
endmodule
